// >>> hw/hcc_pkg.sv
// hcc_pkg: register map, field positions and constants for the cursor control bank.
// assumes a 4-bit direct register address and an 8-bit indirect index from the host port.
package hcc_pkg;
   localparam logic [3:0] DIR_CTRL_ADDR   = 4'h9;
   localparam logic [3:0] DIR_RAM_ADDR    = 4'h0;
   localparam logic [3:0] DIR_XLO_ADDR    = 4'hC;
   localparam logic [3:0] DIR_XHI_ADDR    = 4'hD;
   localparam logic [3:0] DIR_YLO_ADDR    = 4'hE;
   localparam logic [3:0] DIR_YHI_ADDR    = 4'hF;
   localparam logic [7:0] IND_CTRL_INDEX  = 8'h06;
   localparam logic [7:0] IND_CTRL_RESET  = 8'h00;
   localparam logic [7:0] DIR_CTRL_RESET  = 8'h00;
   localparam int         SEL_BIT         = 7;
   localparam int         SENSE_BIT       = 6;
   localparam int         ILACE_BIT       = 5;
   localparam int         VBLEN_BIT       = 4;
   localparam int         RAMHI_MSB       = 3;
   localparam int         RAMHI_LSB       = 2;
   localparam int         MODE_MSB        = 1;
   localparam int         MODE_LSB        = 0;
   localparam int         NIB_MSB         = 3;
   localparam int         VBLANK_SHORT    = 2048;
   localparam int         VBLANK_LONG     = 4096;
   localparam int         VB_CNT_W        = 13;
   typedef enum logic [1:0] {
      HCC_MODE_OFF   = 2'h0,
      HCC_MODE_THREE = 2'h1,
      HCC_MODE_PLNA  = 2'h2,
      HCC_MODE_PLNB  = 2'h3
   } hcc_mode_e;
endpackage

// >>> hw/hcc_vblank_detect.sv
// hcc_vblank_detect: recognises vertical blank from the blanking level alone.
// assumes blank_in is already synchronised to the dot clock.
`timescale 1ns/1ps
module hcc_vblank_detect #(
   parameter int CNT_W = hcc_pkg::VB_CNT_W
) (
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic blank_in,
   input  wire logic long_in,
   output logic      vblank_out
);
   logic             blank_q;
   logic [CNT_W-1:0] count;
   logic             rise;
   logic [CNT_W-1:0] limit;
   logic             reached;

   // the long count of 4096 needs thirteen bits to be reached at all
   if (CNT_W < 13) begin : g_width_check
      $error("vblank counter too narrow");
   end

   assign rise    = blank_in & ~blank_q;
   assign limit   = long_in ? CNT_W'(hcc_pkg::VBLANK_LONG) : CNT_W'(hcc_pkg::VBLANK_SHORT);
   assign reached = (count >= limit);

   // counter saturates so a long blank interval never wraps to a short one
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         blank_q    <= 1'b0;
         count      <= '0;
         vblank_out <= 1'b0;
      end else begin
         blank_q <= blank_in;
         if (rise) begin
            count <= '0;
         end else if (!reached) begin
            count <= count + CNT_W'(1);
         end
         if (rise) begin
            vblank_out <= 1'b0;
         end else if (reached && blank_in) begin
            vblank_out <= 1'b1;
         end
      end
   end

   gap_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(vblank_out) |-> $past(count) >= $past(limit)) else $error("vblank set early");
endmodule

// >>> hw/hcc_cursor_ctrl.sv
// hcc_cursor_ctrl: cursor control and position register bank on the dot clock.
// assumes the host port is synchronous to REF_CLK_IN; video pins pass a 3-flop synchroniser.
// Function
// - select bit picks indirect or direct mode
// - sense invert flips odd/even field polarity
// - interlace enable activates field-based cursor
// - vblank after 2048 or 4096 clocks
// - high bits form RAM address 9:8
// - indirect mode: off, three-color, two plane formats
// - direct control mode bits 1:0, rest zero
// - indirect control at index 6, resets 0
// - X position twelve bits, low/high bytes
// - Y position twelve bits, low/high bytes
// - positions 0..4095 mark lower right corner
// - zero X or Y hides cursor
// - positions have no reset, always accessible
`timescale 1ns/1ps
module hcc_cursor_ctrl (
   input  wire logic        REF_CLK_IN,
   input  wire logic        SYS_RST_IN,
   input  wire logic        DIR_WR_IN,
   input  wire logic        DIR_RD_IN,
   input  wire logic [3:0]  DIR_ADDR_IN,
   input  wire logic [7:0]  IND_INDEX_IN,
   input  wire logic        IND_WR_IN,
   input  wire logic        IND_RD_IN,
   input  wire logic [7:0]  WR_DATA_IN,
   input  wire logic [7:0]  RAM_ADDR_LOW_IN,
   input  wire logic        BLANK_IN,
   input  wire logic        ODD_EVEN_IN,
   output logic      [7:0]  RD_DATA_OUT,
   output logic             RD_VALID_OUT,
   output logic      [1:0]  CURSOR_MODE_OUT,
   output logic             CURSOR_VISIBLE_OUT,
   output logic             INTERLACE_OUT,
   output logic             ODD_FIELD_OUT,
   output logic             VBLANK_OUT,
   output logic      [9:0]  CURSOR_RAM_ADDR_OUT,
   output logic      [11:0] CURSOR_X_POS_OUT,
   output logic      [11:0] CURSOR_Y_POS_OUT
);
   logic [7:0]  ctrl_ind;
   logic [1:0]  cursor_mode_direct;
   logic [11:0] cursor_x_pos;
   logic [11:0] cursor_y_pos;
   logic [2:0]  blank_sync;
   logic [2:0]  field_sync;
   logic        blank_s;
   logic        field_s;

   // decode
   wire wr_ind_ctrl = IND_WR_IN && (IND_INDEX_IN == hcc_pkg::IND_CTRL_INDEX);
   wire rd_ind_ctrl = IND_RD_IN && (IND_INDEX_IN == hcc_pkg::IND_CTRL_INDEX);
   wire wr_dctrl    = DIR_WR_IN && (DIR_ADDR_IN == hcc_pkg::DIR_CTRL_ADDR);
   wire wr_xlo      = DIR_WR_IN && (DIR_ADDR_IN == hcc_pkg::DIR_XLO_ADDR);
   wire wr_xhi      = DIR_WR_IN && (DIR_ADDR_IN == hcc_pkg::DIR_XHI_ADDR);
   wire wr_ylo      = DIR_WR_IN && (DIR_ADDR_IN == hcc_pkg::DIR_YLO_ADDR);
   wire wr_yhi      = DIR_WR_IN && (DIR_ADDR_IN == hcc_pkg::DIR_YHI_ADDR);

   wire       use_direct   = ctrl_ind[hcc_pkg::SEL_BIT];
   wire       sense_invert = ctrl_ind[hcc_pkg::SENSE_BIT];
   wire       ilace_en     = ctrl_ind[hcc_pkg::ILACE_BIT];
   wire       vb_long      = ctrl_ind[hcc_pkg::VBLEN_BIT];
   wire [1:0] ram_hi       = ctrl_ind[hcc_pkg::RAMHI_MSB:hcc_pkg::RAMHI_LSB];
   wire [1:0] mode_ind     = ctrl_ind[hcc_pkg::MODE_MSB:hcc_pkg::MODE_LSB];
   // mode field decodes off/three-color/two-plane A/B downstream
   wire [1:0] eff_mode     = use_direct ? cursor_mode_direct : mode_ind;
   wire       pos_zero     = (cursor_x_pos == 12'h000) || (cursor_y_pos == 12'h000);

   // mux for direct reads; reserved bits come back zero
   logic [7:0] dir_rd;
   always_comb begin
      case (DIR_ADDR_IN)
         hcc_pkg::DIR_CTRL_ADDR: dir_rd = {6'h00, cursor_mode_direct};
         hcc_pkg::DIR_XLO_ADDR:  dir_rd = cursor_x_pos[7:0];
         hcc_pkg::DIR_XHI_ADDR:  dir_rd = {4'h0, cursor_x_pos[11:8]};
         hcc_pkg::DIR_YLO_ADDR:  dir_rd = cursor_y_pos[7:0];
         hcc_pkg::DIR_YHI_ADDR:  dir_rd = {4'h0, cursor_y_pos[11:8]};
         default:                dir_rd = 8'h00;
      endcase
   end
   wire [7:0] ind_rd = rd_ind_ctrl ? ctrl_ind : 8'h00;

   assign blank_s = blank_sync[2];
   assign field_s = field_sync[2];

   // control registers reset; field polarity change counts once stages 2 and 3 agree
   logic field_stable;
   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         ctrl_ind           <= hcc_pkg::IND_CTRL_RESET;
         cursor_mode_direct <= hcc_pkg::DIR_CTRL_RESET[1:0];
         blank_sync         <= 3'h0;
         field_sync         <= 3'h0;
         field_stable       <= 1'b0;
         RD_DATA_OUT        <= 8'h00;
         RD_VALID_OUT       <= 1'b0;
      end else begin
         blank_sync <= {blank_sync[1:0], BLANK_IN};
         field_sync <= {field_sync[1:0], ODD_EVEN_IN};
         if (field_sync[2] == field_sync[1]) begin
            field_stable <= field_sync[2];
         end
         if (wr_ind_ctrl) begin
            ctrl_ind <= WR_DATA_IN;
         end
         if (wr_dctrl) begin
            cursor_mode_direct <= WR_DATA_IN[1:0];
         end
         RD_VALID_OUT <= DIR_RD_IN | IND_RD_IN;
         RD_DATA_OUT  <= DIR_RD_IN ? dir_rd : ind_rd;
      end
   end

   // positions are left uninitialised by design; writes accepted at any time
   always_ff @(posedge REF_CLK_IN) begin
      if (wr_xlo) cursor_x_pos[7:0]  <= WR_DATA_IN;
      if (wr_xhi) cursor_x_pos[11:8] <= WR_DATA_IN[hcc_pkg::NIB_MSB:0];
      if (wr_ylo) cursor_y_pos[7:0]  <= WR_DATA_IN;
      if (wr_yhi) cursor_y_pos[11:8] <= WR_DATA_IN[hcc_pkg::NIB_MSB:0];
   end

   // outputs; positions pass as lower right corner coordinates
   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         CURSOR_MODE_OUT     <= hcc_pkg::HCC_MODE_OFF;
         CURSOR_VISIBLE_OUT  <= 1'b0;
         INTERLACE_OUT       <= 1'b0;
         ODD_FIELD_OUT       <= 1'b0;
         CURSOR_RAM_ADDR_OUT <= 10'h000;
         CURSOR_X_POS_OUT    <= 12'h000;
         CURSOR_Y_POS_OUT    <= 12'h000;
      end else begin
         CURSOR_MODE_OUT     <= eff_mode;
         CURSOR_VISIBLE_OUT  <= (eff_mode != hcc_pkg::HCC_MODE_OFF) && !pos_zero;
         INTERLACE_OUT       <= ilace_en;
         ODD_FIELD_OUT       <= ilace_en & (field_stable ^ sense_invert);
         CURSOR_RAM_ADDR_OUT <= {ram_hi, RAM_ADDR_LOW_IN};
         CURSOR_X_POS_OUT    <= cursor_x_pos;
         CURSOR_Y_POS_OUT    <= cursor_y_pos;
      end
   end

   hcc_vblank_detect #(
      .CNT_W (hcc_pkg::VB_CNT_W)
   ) u_vblank (
      .clk_in     (REF_CLK_IN),
      .rst_in     (SYS_RST_IN),
      .blank_in   (blank_s),
      .long_in    (vb_long),
      .vblank_out (VBLANK_OUT)
   );

   mode_sel_a: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      1'b1 |=> CURSOR_MODE_OUT == ($past(ctrl_ind[7]) ? $past(cursor_mode_direct) : $past(ctrl_ind[1:0])))
      else $error("mode source wrong");
   field_pol_a: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      $past(ilace_en) |-> ODD_FIELD_OUT == ($past(field_stable) ^ $past(sense_invert)))
      else $error("field polarity wrong");
   ilace_off_a: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      !$past(ilace_en) |-> !ODD_FIELD_OUT) else $error("field while not interlaced");
   ram_addr_a: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      1'b1 |=> CURSOR_RAM_ADDR_OUT[9:8] == $past(ctrl_ind[3:2])) else $error("ram high bits wrong");
   off_hide_a: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      CURSOR_MODE_OUT == hcc_pkg::HCC_MODE_OFF |-> !CURSOR_VISIBLE_OUT) else $error("off mode visible");
   dctrl_rd_a: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      wr_dctrl ##1 !wr_dctrl ##1 (DIR_RD_IN && DIR_ADDR_IN == hcc_pkg::DIR_CTRL_ADDR && !wr_dctrl)
      |=> RD_DATA_OUT == {6'h00, $past(WR_DATA_IN[1:0], 3)}) else $error("direct ctrl readback");
   ind_reset_a: assert property (@(posedge REF_CLK_IN)
      SYS_RST_IN |=> ctrl_ind == hcc_pkg::IND_CTRL_RESET) else $error("indirect ctrl reset");
   xhi_rd_a: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      DIR_RD_IN && DIR_ADDR_IN == hcc_pkg::DIR_XHI_ADDR |=> RD_DATA_OUT[7:4] == 4'h0) else $error("x high reserved");
   yhi_rd_a: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      DIR_RD_IN && DIR_ADDR_IN == hcc_pkg::DIR_YHI_ADDR |=> RD_DATA_OUT[7:4] == 4'h0) else $error("y high reserved");
   x_store_a: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      wr_xlo |=> ##1 CURSOR_X_POS_OUT[7:0] == $past(WR_DATA_IN, 2)) else $error("x low not stored");
   zero_hide_a: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      pos_zero |=> !CURSOR_VISIBLE_OUT) else $error("zero position visible");
   pos_wr_a: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      wr_ylo |=> cursor_y_pos[7:0] == $past(WR_DATA_IN)) else $error("y low not stored");
   ind_rd_a: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      rd_ind_ctrl && !DIR_RD_IN |=> RD_DATA_OUT == $past(ctrl_ind)) else $error("indirect readback");

   vis_cov_a:   cover property (@(posedge REF_CLK_IN) CURSOR_VISIBLE_OUT);
   direct_cov_a: cover property (@(posedge REF_CLK_IN) use_direct && cursor_mode_direct == hcc_pkg::HCC_MODE_PLNB);
   vb_cov_a:    cover property (@(posedge REF_CLK_IN) $rose(VBLANK_OUT));
   odd_cov_a:   cover property (@(posedge REF_CLK_IN) ilace_en && sense_invert && ODD_FIELD_OUT);
endmodule

// >>> dv/hcc_host.sv
// hcc_host: host processor model on the direct and indirect register maps.
// assumes the bank answers a read one cycle after the strobe edge.
`timescale 1ns/1ps
module hcc_host (
   input  wire logic       clk_in,
   input  wire logic [7:0] rd_data_in,
   input  wire logic       rd_valid_in,
   output logic            dir_wr_out,
   output logic            dir_rd_out,
   output logic            ind_wr_out,
   output logic            ind_rd_out,
   output logic [3:0]      dir_addr_out,
   output logic [7:0]      ind_index_out,
   output logic [7:0]      wr_data_out
);
   initial begin
      {dir_wr_out, dir_rd_out, ind_wr_out, ind_rd_out} = 4'h0;
      {dir_addr_out, ind_index_out, wr_data_out} = 20'h00000;
   end
   task automatic put(input logic ind, input logic [7:0] a);
      dir_addr_out  <= a[3:0];
      ind_index_out <= a;
   endtask
   task automatic wr(input logic ind, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      put(ind, a);
      {dir_wr_out, ind_wr_out} <= {!ind, ind};
      wr_data_out <= d;
      @(posedge clk_in);
      {dir_wr_out, ind_wr_out} <= 2'h0;
      // data no longer held: show a changed value so nothing leans on it
      wr_data_out <= ~d;
   endtask
   task automatic rd(input logic ind, input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      put(ind, a);
      {dir_rd_out, ind_rd_out} <= {!ind, ind};
      @(posedge clk_in);
      {dir_rd_out, ind_rd_out} <= 2'h0;
      #1;
      d = (rd_valid_in === 1'b1) ? rd_data_in : 8'hXX;
   endtask
   task automatic use_direct(input logic [7:0] ctrl);
      wr(1'b1, hcc_pkg::IND_CTRL_INDEX, ctrl | 8'h80);
   endtask
   // upper left corner in, lower right register values out
   task automatic place(input logic [11:0] x, input logic [11:0] y);
      logic [11:0] px, py;
      px = x + 12'h040;
      py = y + 12'h040;
      wr(1'b0, 8'h0C, px[7:0]);
      wr(1'b0, 8'h0D, {4'h0, px[11:8]});
      wr(1'b0, 8'h0E, py[7:0]);
      wr(1'b0, 8'h0F, {4'h0, py[11:8]});
   endtask
endmodule

// >>> dv/test_hcc_cursor_ctrl.sv
// test_hcc_cursor_ctrl: self-checking bench for the cursor control bank.
// assumes the host model above and a 200 MHz dot clock.
`timescale 1ns/1ps
module test_hcc_cursor_ctrl;
   logic        ref_clk = 1'b0, sys_rst = 1'b1, blank = 1'b0, odd_even = 1'b0;
   logic [7:0]  ram_lo = 8'h00, rd_data, ind_index, wr_data, d;
   logic        rd_valid, dir_wr, dir_rd, ind_wr, ind_rd, visible, ilace, odd_field, vblank;
   logic [3:0]  dir_addr;
   logic [1:0]  mode;
   logic [9:0]  ram_addr;
   logic [11:0] x_pos, y_pos;
   int          n_errors = 0, checked = 0, cycles = 0;
   always #2.5 ref_clk = ~ref_clk;
   hcc_cursor_ctrl u_hcc_cursor_ctrl (
      .REF_CLK_IN(ref_clk), .SYS_RST_IN(sys_rst), .DIR_WR_IN(dir_wr), .DIR_RD_IN(dir_rd),
      .DIR_ADDR_IN(dir_addr), .IND_INDEX_IN(ind_index), .IND_WR_IN(ind_wr), .IND_RD_IN(ind_rd),
      .WR_DATA_IN(wr_data), .RAM_ADDR_LOW_IN(ram_lo), .BLANK_IN(blank), .ODD_EVEN_IN(odd_even),
      .RD_DATA_OUT(rd_data), .RD_VALID_OUT(rd_valid), .CURSOR_MODE_OUT(mode),
      .CURSOR_VISIBLE_OUT(visible), .INTERLACE_OUT(ilace), .ODD_FIELD_OUT(odd_field),
      .VBLANK_OUT(vblank), .CURSOR_RAM_ADDR_OUT(ram_addr), .CURSOR_X_POS_OUT(x_pos),
      .CURSOR_Y_POS_OUT(y_pos));
   hcc_host u_hcc_host (
      .clk_in(ref_clk), .rd_data_in(rd_data), .rd_valid_in(rd_valid), .dir_wr_out(dir_wr),
      .dir_rd_out(dir_rd), .ind_wr_out(ind_wr), .ind_rd_out(ind_rd), .dir_addr_out(dir_addr),
      .ind_index_out(ind_index), .wr_data_out(wr_data));
   task automatic stop_test();
      if (n_errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [11:0] g, input logic [11:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic t_reset();
      u_hcc_host.rd(1'b1, 8'h06, d);
      chk({4'h0, d}, 12'h000);
      u_hcc_host.rd(1'b0, 8'h09, d);
      chk({4'h0, d}, 12'h000);
      chk({10'h000, mode}, 12'h000);
   endtask
   task automatic t_pos();
      u_hcc_host.place(12'h000, 12'hF00);
      wait_n(3);
      chk(x_pos, 12'h040);
      chk(y_pos, 12'hF40);
      u_hcc_host.rd(1'b0, 8'h0F, d);
      chk({4'h0, d}, 12'h00F);
      u_hcc_host.wr(1'b0, 8'h0C, 8'hFF);
      u_hcc_host.wr(1'b0, 8'h0D, 8'hFF);
      u_hcc_host.wr(1'b0, 8'h0E, 8'hA5);
      u_hcc_host.rd(1'b0, 8'h0D, d);
      chk({4'h0, d}, 12'h00F);
      u_hcc_host.rd(1'b0, 8'h0E, d);
      chk({4'h0, d}, 12'h0A5);
      chk(x_pos, 12'hFFF);
   endtask
   task automatic t_mode();
      for (int m = 0; m < 4; m++) begin
         u_hcc_host.wr(1'b1, 8'h06, 8'(m));
         wait_n(3);
         chk({10'h000, mode}, 12'(m));
         chk({11'h000, visible}, {11'h000, m != 0});
      end
      u_hcc_host.wr(1'b0, 8'h09, 8'hFE);
      u_hcc_host.rd(1'b0, 8'h09, d);
      chk({4'h0, d}, 12'h002);
      chk({10'h000, mode}, 12'h003);
      u_hcc_host.use_direct(8'h03);
      wait_n(3);
      chk({10'h000, mode}, 12'h002);
      u_hcc_host.rd(1'b1, 8'h06, d);
      chk({4'h0, d}, 12'h083);
      u_hcc_host.wr(1'b0, 8'h03, 8'hFF);
      u_hcc_host.rd(1'b0, 8'h03, d);
      chk({4'h0, d}, 12'h000);
      u_hcc_host.rd(1'b1, 8'h07, d);
      chk({4'h0, d}, 12'h000);
      u_hcc_host.wr(1'b0, 8'h0C, 8'h00);
      u_hcc_host.wr(1'b0, 8'h0D, 8'h00);
      wait_n(3);
      chk({11'h000, visible}, 12'h000);
   endtask
   task automatic t_field();
      ram_lo   <= 8'h5A;
      odd_even <= 1'b1;
      u_hcc_host.wr(1'b1, 8'h06, 8'h2C);
      wait_n(6);
      chk({10'h000, ilace, odd_field}, 12'h003);
      chk({2'h0, ram_addr}, 12'h35A);
      u_hcc_host.wr(1'b1, 8'h06, 8'h6C);
      wait_n(3);
      chk({11'h000, odd_field}, 12'h000);
   endtask
   task automatic t_vblank(input logic lng, input int n);
      u_hcc_host.wr(1'b1, 8'h06, {3'h0, lng, 4'h0});
      blank <= 1'b1;
      wait_n(n - 100);
      chk({11'h000, vblank}, 12'h000);
      wait_n(200);
      chk({11'h000, vblank}, 12'h001);
      blank <= 1'b0;
      wait_n(10);
      blank <= 1'b1;
      wait_n(10);
      chk({11'h000, vblank}, 12'h000);
      blank <= 1'b0;
   endtask
   // ceiling well above the ~6500 cycles the sequence needs
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_pos();
      t_mode();
      t_field();
      t_vblank(1'b0, 2048);
      t_vblank(1'b1, 4096);
      stop_test();
   end
endmodule
